// >>> logic/sfd_flash_decoder.sv
// Purpose: Frame, decode and answer serial flash instructions
// Assumes: Serial clock at most about a fifth of core_clk
// Notes: Array and status contents live outside; bytes stream out
// Behaviour
// RULE1 - Transfers start MSB first after select falls
// RULE2 - Opcode captured on rising edges, MSB first
// RULE3 - One opcode, then address/data as defined
// RULE4 - Host releases select after last input bit
// RULE5 - Read-type instructions stream data out
// RULE6 - Write-type runs only on byte-boundary release
// RULE7 - Partial page byte: nothing, latch kept
// RULE8 - Decode latch, volatile and status opcodes
// RULE9 - Decode single, dual, quad read opcodes
// RULE10 - Decode page program opcodes with address
// RULE11 - Decode sector, block and chip erase
// RULE12 - Decode reset pair, suspend and resume
// RULE13 - Wrap setting: dummies then wrap byte
// RULE14 - Power-down entry, release, repeated part ID
// RULE15 - ID reads alternate maker and part codes
// RULE16 - Write latch gates program, erase, status write
// RULE17 - Power-down ignores all but release
// RULE18 - Unknown opcode ignored until next frame
`timescale 1ns/1ps
`include "sfd_map.svh"
module sfd_flash_decoder #(
  parameter logic [7:0] MAKER_CODE_BYTE = 8'h5A, // Arbitrary value
  parameter logic [7:0] PART_CODE_BYTE = 8'h3C // Arbitrary value
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic chipSelN,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic [7:0] memData,
  input wire logic [7:0] statusByte1,
  input wire logic [7:0] statusByte2,
  input wire logic [7:0] statusByte3,
  output logic [23:0] memAddr,
  output logic [7:0] wrData,
  output logic wrValid,
  output logic execValid,
  output logic [7:0] execOpcode,
  output logic [23:0] execAddr,
  output logic execVolatile,
  output logic softReset,
  output logic writeEnableLatch,
  output logic deepPowerDown,
  output logic [7:0] continuousModeBits,
  output logic [7:0] wrapConfigBits
);
  import sfd_pkg::*;

  // Instruction table
  function automatic sfd_cmd_t decodeOp(input logic [7:0] op);
    sfd_cmd_t c;
    c = '0;
    c.known = 1'b1;
    c.src = SRC_NONE;
    case (op)
      `SFD_OP_WR_ENABLE, `SFD_OP_WR_DISABLE,
      `SFD_OP_POWER_DOWN: c.isWrite = 1'b1; // RULE8 RULE14
      `SFD_OP_VOL_ENABLE, `SFD_OP_RESET_EN, `SFD_OP_RESET,
      `SFD_OP_SUSPEND, `SFD_OP_RESUME: c.known = 1'b1; // RULE12
      `SFD_OP_STAT_RD1: c.src = SRC_STAT1; // RULE8
      `SFD_OP_STAT_RD2: c.src = SRC_STAT2;
      `SFD_OP_STAT_RD3: c.src = SRC_STAT3;
      `SFD_OP_STAT_WR1, `SFD_OP_STAT_WR2, `SFD_OP_STAT_WR3: begin
        c.dataIn = 1'b1; // RULE8
        c.isWrite = 1'b1;
        c.needWel = 1'b1;
      end
      `SFD_OP_READ, `SFD_OP_FAST_READ, `SFD_OP_DUAL_OUT,
      `SFD_OP_QUAD_OUT: begin
        c.hasAddr = 1'b1; // RULE9
        c.src = SRC_MEM;
        if (op != `SFD_OP_READ) c.dummyClk = `SFD_DUMMY_FAST;
        if (op == `SFD_OP_DUAL_OUT) c.dataLanes = `SFD_LANE2;
        if (op == `SFD_OP_QUAD_OUT) c.dataLanes = `SFD_LANE4;
      end
      `SFD_OP_DUAL_IO, `SFD_OP_ID_DUAL: begin
        c.hasAddr = 1'b1; // RULE9 RULE15
        c.hasMode = 1'b1;
        c.addrLanes = `SFD_LANE2;
        c.dataLanes = `SFD_LANE2;
        c.src = (op == `SFD_OP_ID_DUAL) ? SRC_IDPAIR : SRC_MEM;
      end
      `SFD_OP_QUAD_IO, `SFD_OP_QUAD_WORD, `SFD_OP_ID_QUAD: begin
        c.hasAddr = 1'b1; // RULE9 RULE15
        c.hasMode = 1'b1;
        c.addrLanes = `SFD_LANE4;
        c.dataLanes = `SFD_LANE4;
        c.dummyClk = (op == `SFD_OP_QUAD_WORD) ? `SFD_DUMMY_WORD
                                               : `SFD_DUMMY_QIO;
        c.src = (op == `SFD_OP_ID_QUAD) ? SRC_IDPAIR : SRC_MEM;
      end
      `SFD_OP_PAGE_PROG, `SFD_OP_FAST_PROG, `SFD_OP_QUAD_PROG: begin
        c.hasAddr = 1'b1; // RULE10
        c.dataIn = 1'b1;
        c.isWrite = 1'b1;
        c.needWel = 1'b1;
        if (op == `SFD_OP_QUAD_PROG) c.dataLanes = `SFD_LANE4;
      end
      `SFD_OP_SECT_ERASE, `SFD_OP_BLK32_ERASE,
      `SFD_OP_BLK64_ERASE: begin
        c.hasAddr = 1'b1; // RULE11
        c.isWrite = 1'b1;
        c.needWel = 1'b1;
      end
      `SFD_OP_CHIP_ERASE_A, `SFD_OP_CHIP_ERASE_B: begin
        c.isWrite = 1'b1; // RULE11
        c.needWel = 1'b1;
      end
      `SFD_OP_WRAP: begin
        c.dummyClk = `SFD_DUMMY_WRAP; // RULE13
        c.dataIn = 1'b1;
        c.dataLanes = `SFD_LANE4;
      end
      `SFD_OP_RELEASE: begin
        c.dummyClk = `SFD_DUMMY_ID; // RULE14
        c.src = SRC_PART;
      end
      `SFD_OP_ID_SINGLE: begin
        c.hasAddr = 1'b1; // RULE15
        c.src = SRC_IDPAIR;
      end
      default: c.known = 1'b0; // RULE18
    endcase
    return c;
  endfunction

  // Phase that follows the one just finished
  function automatic sfd_state_t afterPhase(input sfd_cmd_t c,
                                            input sfd_state_t s);
    sfd_state_t n;
    n = ST_WAIT;
    if (c.dataIn) n = ST_DIN;
    else if (c.src != SRC_NONE) n = ST_DOUT; // RULE5
    if (c.dummyClk != 5'h00 && s != ST_DUMMY) n = ST_DUMMY;
    if (c.hasMode && (s == ST_OPC || s == ST_ADDR)) n = ST_MODE;
    if (c.hasAddr && s == ST_OPC) n = ST_ADDR; // RULE3
    if (!c.known) n = ST_WAIT;
    return n;
  endfunction

  // Serial clocks that a phase lasts
  function automatic logic [4:0] phaseLen(input sfd_cmd_t c,
                                          input sfd_state_t s);
    logic [4:0] n;
    n = `SFD_BYTE_BITS;
    if (s == ST_ADDR) n = `SFD_ADDR_BITS >> c.addrLanes;
    if (s == ST_MODE) n = `SFD_BYTE_BITS >> c.addrLanes;
    if (s == ST_DUMMY) n = c.dummyClk;
    if (s == ST_DIN || s == ST_DOUT) n = `SFD_BYTE_BITS >> c.dataLanes;
    return n;
  endfunction

  logic sclkRise, sclkFall, csFall, csRise, csActive;
  logic [3:0] ioSync; // Synchronised data lanes
  sfd_state_t state; // Frame sequencer state
  logic [4:0] phaseLeft; // Clocks left in this phase or byte
  logic [2:0] clkCnt; // Rising edges since select fell, modulo 8
  logic [23:0] shiftIn; // Input shifter
  logic [7:0] opcode; // Opcode of the current frame
  logic frameIgnored; // Frame dropped: unknown or powered down
  logic gotByte; // At least one whole data byte taken
  logic [23:0] addrReg; // Captured address
  logic loadReq; // Fetch next outgoing byte
  logic [7:0] shiftOut; // Output shifter
  logic [3:0] outBits; // Lane values on the pins
  logic outLive; // First falling edge of output seen
  logic idToggle; // Maker or part byte next
  logic volWen; // Volatile status write armed
  logic resetArmed; // Reset enable seen

  sfd_pin_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .spiClk(spiClk),
    .chipSelN(chipSelN),
    .ioIn(ioIn),
    .sclkRise(sclkRise),
    .sclkFall(sclkFall),
    .csFall(csFall),
    .csRise(csRise),
    .csActive(csActive),
    .ioSync(ioSync)
  );

  // Decode of the opcode being completed and of the held one
  wire rise = sclkRise & csActive;
  wire phaseEnd = rise && phaseLeft == 5'h01;
  wire [7:0] newOp = {shiftIn[6:0], ioSync[0]}; // RULE2
  wire sfd_cmd_t newCmd = decodeOp(newOp);
  wire sfd_cmd_t curCmd = decodeOp(opcode);
  wire sfd_cmd_t execCmd = decodeOp(execOpcode); // Shape of accepted one
  wire sfd_cmd_t phaseCmd = (state == ST_OPC) ? newCmd : curCmd;
  wire blocked = !newCmd.known ||
                 (deepPowerDown && newOp != `SFD_OP_RELEASE); // RULE17
  wire [1:0] inLanes = (state == ST_OPC) ? `SFD_LANE1 :
                       (state == ST_DIN) ? curCmd.dataLanes :
                       curCmd.addrLanes;
  wire [23:0] nextShift = (inLanes == `SFD_LANE4) ?
                          {shiftIn[19:0], ioSync} :
                          (inLanes == `SFD_LANE2) ?
                          {shiftIn[21:0], ioSync[1:0]} :
                          {shiftIn[22:0], ioSync[0]};
  wire sfd_state_t nextState =
    (state == ST_OPC && blocked) ? ST_WAIT :
    (state == ST_DIN || state == ST_DOUT) ? state :
    afterPhase(phaseCmd, state);
  wire [4:0] nextLen = phaseLen(phaseCmd, nextState);

  // Sequencer: opcode, address, mode, dummy and input data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      phaseLeft <= `SFD_BYTE_BITS;
      clkCnt <= `SFD_BOUNDARY;
      shiftIn <= 24'h000000;
      opcode <= 8'h00;
      frameIgnored <= 1'b0;
      gotByte <= 1'b0;
      addrReg <= 24'h000000;
      continuousModeBits <= 8'h00;
      wrData <= 8'h00;
      wrValid <= 1'b0;
      loadReq <= 1'b0;
    end else begin
      wrValid <= 1'b0;
      loadReq <= 1'b0;
      if (csRise) begin
        state <= ST_IDLE; // RULE18
      end else if (csFall) begin
        state <= ST_OPC; // RULE1
        phaseLeft <= `SFD_BYTE_BITS;
        clkCnt <= `SFD_BOUNDARY;
        frameIgnored <= 1'b0;
        gotByte <= 1'b0;
      end else if (rise && state != ST_WAIT && state != ST_IDLE) begin
        clkCnt <= clkCnt + 3'h1;
        shiftIn <= nextShift;
        phaseLeft <= phaseEnd ? nextLen : phaseLeft - 5'h01;
        if (phaseEnd) begin
          state <= nextState;
          loadReq <= (nextState == ST_DOUT); // RULE5
          if (state == ST_OPC) begin
            opcode <= newOp; // RULE2
            frameIgnored <= blocked; // RULE17 RULE18
          end
          if (state == ST_ADDR) addrReg <= nextShift;
          if (state == ST_MODE) continuousModeBits <= nextShift[7:0];
          if (state == ST_DIN) begin
            wrData <= nextShift[7:0];
            wrValid <= 1'b1;
            gotByte <= 1'b1;
          end
        end
      end else if (rise) begin
        clkCnt <= clkCnt + 3'h1; // Still counted for boundary checks
      end
    end
  end

  // Outgoing byte source
  wire [7:0] srcByte =
    (curCmd.src == SRC_MEM) ? memData :
    (curCmd.src == SRC_STAT1) ? statusByte1 :
    (curCmd.src == SRC_STAT2) ? statusByte2 :
    (curCmd.src == SRC_STAT3) ? statusByte3 :
    (curCmd.src == SRC_IDPAIR && !idToggle) ? MAKER_CODE_BYTE :
    PART_CODE_BYTE; // RULE14 RULE15
  wire [2:0] outStep = 3'h1 << curCmd.dataLanes;
  wire [3:0] laneMask = (curCmd.dataLanes == `SFD_LANE4) ? 4'hF :
                        (curCmd.dataLanes == `SFD_LANE2) ? 4'h3 : 4'h2;
  wire addrDone = phaseEnd && state == ST_ADDR;

  // Output shifter; bits change on falling serial clock edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shiftOut <= 8'h00;
      outBits <= 4'h0;
      outLive <= 1'b0;
      idToggle <= 1'b0;
      memAddr <= 24'h000000;
    end else begin
      if (csFall) begin
        outLive <= 1'b0;
        idToggle <= 1'b0;
      end
      if (addrDone) memAddr <= nextShift;
      if (loadReq) begin
        shiftOut <= srcByte; // RULE5
        idToggle <= ~idToggle;
        if (curCmd.src == SRC_MEM) memAddr <= memAddr + 24'h000001;
      end else if (sclkFall && csActive && state == ST_DOUT) begin
        outBits <= (curCmd.dataLanes == `SFD_LANE4) ? shiftOut[7:4] :
                   (curCmd.dataLanes == `SFD_LANE2) ?
                   {2'h0, shiftOut[7:6]} : {2'h0, shiftOut[7], 1'b0};
        shiftOut <= shiftOut << outStep;
        outLive <= 1'b1;
      end
    end
  end

  assign ioOut = outBits;
  assign ioOe = (state == ST_DOUT && outLive) ? laneMask : 4'h0; // RULE5

  // Acceptance at select release
  wire isStatWrite = opcode == `SFD_OP_STAT_WR1 ||
                     opcode == `SFD_OP_STAT_WR2 ||
                     opcode == `SFD_OP_STAT_WR3;
  wire welOk = !curCmd.needWel || writeEnableLatch ||
               (volWen && isStatWrite); // RULE16
  wire writeDone = clkCnt == `SFD_BOUNDARY &&
                   (state == ST_WAIT ||
                    (state == ST_DIN && gotByte)); // RULE6 RULE7
  wire accept = csRise && state != ST_IDLE && state != ST_OPC &&
                !frameIgnored && welOk &&
                (!curCmd.isWrite || writeDone); // RULE4
  wire welClear = curCmd.needWel || opcode == `SFD_OP_WR_DISABLE;

  // Latches and execution strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      execValid <= 1'b0;
      execOpcode <= 8'h00;
      execAddr <= 24'h000000;
      execVolatile <= 1'b0;
      softReset <= 1'b0;
      writeEnableLatch <= 1'b0;
      deepPowerDown <= 1'b0;
      volWen <= 1'b0;
      resetArmed <= 1'b0;
      wrapConfigBits <= 8'h00;
    end else begin
      execValid <= accept;
      softReset <= 1'b0;
      if (wrValid && opcode == `SFD_OP_WRAP) wrapConfigBits <= wrData;
      if (accept) begin
        execOpcode <= opcode;
        execAddr <= addrReg;
        execVolatile <= volWen && isStatWrite;
        volWen <= (opcode == `SFD_OP_VOL_ENABLE); // RULE8
        resetArmed <= (opcode == `SFD_OP_RESET_EN); // RULE12
        if (opcode == `SFD_OP_WR_ENABLE) writeEnableLatch <= 1'b1;
        else if (welClear) writeEnableLatch <= 1'b0; // RULE8 RULE16
        if (opcode == `SFD_OP_POWER_DOWN) deepPowerDown <= 1'b1;
        if (opcode == `SFD_OP_RELEASE) deepPowerDown <= 1'b0; // RULE14
        if (opcode == `SFD_OP_RESET && resetArmed) begin
          softReset <= 1'b1; // RULE12
          writeEnableLatch <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence lastOpcodeBit;
    state == ST_OPC && phaseEnd;
  endsequence
  sequence partialPageRelease;
    csRise && state == ST_DIN && opcode == `SFD_OP_PAGE_PROG &&
    clkCnt != `SFD_BOUNDARY;
  endsequence

  frame_start_a: assert property (csFall && !csRise |=> // RULE1
    state == ST_OPC && clkCnt == 3'h0 && phaseLeft == 5'h08)
    else $error("frame did not start at opcode bit seven");
  opcode_msb_a: assert property (lastOpcodeBit |=> // RULE2
    opcode == {$past(shiftIn[6:0]), $past(ioSync[0])})
    else $error("opcode not assembled msb first");
  addr_follows_a: assert property (lastOpcodeBit and // RULE3
    newCmd.hasAddr && !blocked |=> state == ST_ADDR)
    else $error("address phase missing after opcode");
  out_phase_a: assert property (ioOe != 4'h0 |-> // RULE5
    state == ST_DOUT) else $error("pins driven outside output phase");
  boundary_write_a: assert property (execValid && // RULE6
    execCmd.isWrite |-> $past(clkCnt) == 3'h0)
    else $error("write accepted off a byte boundary");
  partial_page_a: assert property (partialPageRelease |=> // RULE7
    !execValid && writeEnableLatch == $past(writeEnableLatch))
    else $error("partial page byte had an effect");
  wel_disable_a: assert property (execValid && // RULE8
    execOpcode == `SFD_OP_WR_DISABLE |-> !writeEnableLatch)
    else $error("write latch left set after disable");
  wel_gate_a: assert property (execValid && // RULE16
    execCmd.needWel && !execVolatile |->
    $past(writeEnableLatch)) else $error("write ran without latch");
  pd_ignore_a: assert property (execValid && // RULE17
    $past(deepPowerDown, 2) |-> execOpcode == `SFD_OP_RELEASE)
    else $error("instruction run in deep power-down");
  unknown_skip_a: assert property (lastOpcodeBit and // RULE18
    !newCmd.known |=> state == ST_WAIT ##1 !execValid[*2])
    else $error("unknown opcode not ignored");
endmodule // sfd_flash_decoder

// >>> logic/sfd_map.svh
// Purpose: Opcodes and timing counts for the serial flash decoder
// Assumes: Included by the decoder top and by the test bench
// Notes: Counts are in serial clock edges, not core clock cycles
`ifndef SFD_MAP_SVH
`define SFD_MAP_SVH

// Write latch and status access
`define SFD_OP_WR_ENABLE 8'h06
`define SFD_OP_WR_DISABLE 8'h04
`define SFD_OP_VOL_ENABLE 8'h50
`define SFD_OP_STAT_RD1 8'h05
`define SFD_OP_STAT_RD2 8'h35
`define SFD_OP_STAT_RD3 8'h15
`define SFD_OP_STAT_WR1 8'h01
`define SFD_OP_STAT_WR2 8'h31
`define SFD_OP_STAT_WR3 8'h11
// Array reads
`define SFD_OP_READ 8'h03
`define SFD_OP_FAST_READ 8'h0B
`define SFD_OP_DUAL_OUT 8'h3B
`define SFD_OP_QUAD_OUT 8'h6B
`define SFD_OP_DUAL_IO 8'hBB
`define SFD_OP_QUAD_IO 8'hEB
`define SFD_OP_QUAD_WORD 8'hE7
// Program and erase
`define SFD_OP_PAGE_PROG 8'h02
`define SFD_OP_QUAD_PROG 8'h32
`define SFD_OP_FAST_PROG 8'hF2
`define SFD_OP_SECT_ERASE 8'h20
`define SFD_OP_BLK32_ERASE 8'h52
`define SFD_OP_BLK64_ERASE 8'hD8
`define SFD_OP_CHIP_ERASE_A 8'hC7
`define SFD_OP_CHIP_ERASE_B 8'h60
// Control
`define SFD_OP_RESET_EN 8'h66
`define SFD_OP_RESET 8'h99
`define SFD_OP_SUSPEND 8'h75
`define SFD_OP_RESUME 8'h7A
`define SFD_OP_WRAP 8'h77
`define SFD_OP_POWER_DOWN 8'hB9
`define SFD_OP_RELEASE 8'hAB
// Identification
`define SFD_OP_ID_SINGLE 8'h90
`define SFD_OP_ID_DUAL 8'h92
`define SFD_OP_ID_QUAD 8'h94

// Lane codes: log2 of the lane count
`define SFD_LANE1 2'h0
`define SFD_LANE2 2'h1
`define SFD_LANE4 2'h2
// Phase lengths in bits or clocks
`define SFD_ADDR_BITS 5'h18
`define SFD_BYTE_BITS 5'h08
`define SFD_DUMMY_FAST 5'h08
`define SFD_DUMMY_QIO 5'h04
`define SFD_DUMMY_WORD 5'h02
`define SFD_DUMMY_WRAP 5'h06
`define SFD_DUMMY_ID 5'h18
// Clock count modulo eight at a byte boundary
`define SFD_BOUNDARY 3'h0

`endif

// >>> logic/sfd_pkg.sv
// Purpose: Types shared by the serial flash decoder files
// Assumes: Map header provides the numeric constants
// Notes: States are one-hot
package sfd_pkg;

  // Frame sequencer states
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_OPC   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_MODE  = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DIN   = 8'h20,
    ST_DOUT  = 8'h40,
    ST_WAIT  = 8'h80
  } sfd_state_t;

  // Where outgoing bytes come from
  typedef enum logic [2:0] {
    SRC_NONE, SRC_MEM, SRC_STAT1, SRC_STAT2, SRC_STAT3, SRC_PART, SRC_IDPAIR
  } sfd_src_t;

  // Shape of one instruction
  typedef struct packed {
    logic known;
    logic hasAddr;
    logic hasMode;
    logic [1:0] addrLanes;
    logic [4:0] dummyClk;
    logic dataIn;
    logic [1:0] dataLanes;
    logic isWrite;
    logic needWel;
    sfd_src_t src;
  } sfd_cmd_t;

endpackage

// >>> logic/sfd_pin_sync.sv
// Purpose: Bring the serial pins into the core clock and find edges
// Assumes: Serial clock half period spans several core clocks
// Notes: Clock, select and data share one latency so they stay aligned
`timescale 1ns/1ps
module sfd_pin_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic chipSelN,
  input wire logic [3:0] ioIn,
  output logic sclkRise,
  output logic sclkFall,
  output logic csFall,
  output logic csRise,
  output logic csActive,
  output logic [3:0] ioSync
);
  logic [5:0] stage1; // First flop, read only by stage2
  logic [5:0] stage2; // Settled copy of the pins
  logic sclkPrev; // Delayed clock for edge finding
  logic csPrevN; // Delayed select for edge finding

  // Two flops per pin, then one more for edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Idle levels: clock low, select and lanes high, so no false edge
      stage1 <= 6'h1F;
      stage2 <= 6'h1F;
      sclkPrev <= 1'b0;
      csPrevN <= 1'b1;
    end else begin
      stage1 <= {spiClk, chipSelN, ioIn};
      stage2 <= stage1;
      sclkPrev <= stage2[5];
      csPrevN <= stage2[4];
    end
  end

  assign sclkRise = stage2[5] & ~sclkPrev;
  assign sclkFall = ~stage2[5] & sclkPrev;
  assign csFall = ~stage2[4] & csPrevN;
  assign csRise = stage2[4] & ~csPrevN;
  assign csActive = ~stage2[4];
  assign ioSync = stage2[3:0];
endmodule // sfd_pin_sync

// >>> verif/sfd_host_model.sv
// Purpose: Host serial master that frames instructions for the decoder
// Assumes: Clock idles low, 400 ns period, own timeline
// Notes: Clock stands still between frames; released lanes keep toggling
`timescale 1ns/1ps
module sfd_host_model (
  output logic spiClk,
  output logic chipSelN,
  output logic [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe
);
  localparam time HALF = 200; // Half of the serial period
  // Idle pins at time zero
  initial begin
    spiClk = 1'b0;
    chipSelN = 1'b1;
    ioIn = 4'hF;
  end
  // Select falls; the next rising edge carries the top bit
  task automatic open_frame();
    chipSelN = 1'b0;
    #HALF;
  endtask
  // Lowest n bits of val, MSB first, set while the clock is low
  task automatic send_bits(input logic [31:0] val, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      ioIn[0] = val[i];
      #HALF spiClk = 1'b1;
      #HALF spiClk = 1'b0;
    end
  endtask
  // n nibbles of val on all four lanes, top nibble first
  task automatic send_quad(input logic [31:0] val, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      ioIn = val[4*i +: 4];
      #HALF spiClk = 1'b1;
      #HALF spiClk = 1'b0;
    end
  endtask
  // One byte from lane 1, taken at each rising edge
  task automatic get_byte(output logic [7:0] val);
    for (int i = 7; i >= 0; i--) begin
      ioIn = ~ioIn; // Unused lanes change so no stale level is trusted
      #HALF spiClk = 1'b1;
      val[i] = ioOe[1] ? ioOut[1] : ~ioOut[1]; // Undriven line is untrusted
      #HALF spiClk = 1'b0;
    end
  endtask
  // Select rises only after the last bit, with the clock low again
  task automatic close_frame();
    chipSelN = 1'b1;
    ioIn = ~ioIn;
    #(2 * HALF);
  endtask
endmodule // sfd_host_model

// >>> verif/sfd_flash_decoder_test.sv
// Purpose: Self-checking bench for the serial flash decoder
// Assumes: Host model drives the pins on its own timeline
// Notes: Array bytes come from a fixed function of the read address
`timescale 1ns/1ps
`include "sfd_map.svh"
module sfd_flash_decoder_test;
  import sfd_pkg::*;
  logic core_clk, rst, spiClk, chipSelN, wrValid, execValid, execVolatile;
  logic softReset, writeEnableLatch, deepPowerDown;
  logic [3:0] ioIn, ioOut, ioOe;
  logic [7:0] memData, statusByte1, statusByte2, statusByte3, wrData;
  logic [7:0] execOpcode, continuousModeBits, wrapConfigBits, b0, b1;
  logic [23:0] memAddr, execAddr;
  int bad_count = 0, tests_run = 0, execCount = 0, softCount = 0, n;
  assign memData = memAddr[7:0] ^ 8'hC3; // Array model: address-derived
  sfd_flash_decoder dut_u (.core_clk(core_clk), .rst(rst), .spiClk(spiClk),
    .chipSelN(chipSelN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .memData(memData), .statusByte1(statusByte1),
    .statusByte2(statusByte2), .statusByte3(statusByte3),
    .memAddr(memAddr), .wrData(wrData), .wrValid(wrValid),
    .execValid(execValid), .execOpcode(execOpcode), .execAddr(execAddr),
    .execVolatile(execVolatile), .softReset(softReset),
    .writeEnableLatch(writeEnableLatch), .deepPowerDown(deepPowerDown),
    .continuousModeBits(continuousModeBits),
    .wrapConfigBits(wrapConfigBits));
  sfd_host_model host_u (.spiClk(spiClk), .chipSelN(chipSelN),
    .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
  // Core clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Count one-cycle pulses of accept and soft reset
  always @(posedge core_clk) begin
    if (execValid === 1'b1) execCount++;
    if (softReset === 1'b1) softCount++;
  end
  task automatic check(input string what, input logic [23:0] e,
                       input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole input-only frame, then time for the accept to land
  task automatic frame(input logic [31:0] v, input int bits);
    host_u.open_frame();
    host_u.send_bits(v, bits);
    host_u.close_frame();
    repeat (10) @(posedge core_clk);
    #1;
  endtask
  task automatic t_latch();
    frame(`SFD_OP_WR_ENABLE, 8);
    check("wel set", 1, writeEnableLatch);
    check("opcode", `SFD_OP_WR_ENABLE, execOpcode);
    frame({`SFD_OP_WR_DISABLE, 1'b0}, 9);
    check("wel after 9 clocks", 1, writeEnableLatch);
    frame(`SFD_OP_WR_DISABLE, 8);
    check("wel cleared", 0, writeEnableLatch);
    n = execCount;
    frame(`SFD_OP_VOL_ENABLE, 8);
    check("volatile accept", n + 1, execCount);
    check("wel after 50", 0, writeEnableLatch);
    frame({`SFD_OP_STAT_WR1, 8'h5C}, 16);
    check("volatile write", 1, execVolatile);
    check("status data", 8'h5C, wrData);
  endtask
  task automatic t_status();
    logic [7:0] ops [3] = '{`SFD_OP_STAT_RD1, `SFD_OP_STAT_RD2,
                            `SFD_OP_STAT_RD3};
    @(posedge core_clk) #1;
    statusByte1 = 8'hA5;
    statusByte2 = 8'h3C;
    statusByte3 = 8'hE1;
    for (int i = 0; i < 3; i++) begin
      host_u.open_frame();
      host_u.send_bits(ops[i], 8);
      host_u.get_byte(b0);
      check("single lane drive", 4'h2, ioOe);
      host_u.close_frame();
      check("status byte", i == 0 ? 8'hA5 : i == 1 ? 8'h3C : 8'hE1,
            b0);
    end
  endtask
  task automatic t_program();
    n = execCount;
    frame({`SFD_OP_PAGE_PROG, 24'h00AB10}, 32);
    check("program no latch", n, execCount);
    frame(`SFD_OP_WR_ENABLE, 8);
    n = execCount;
    host_u.open_frame();
    host_u.send_bits({`SFD_OP_PAGE_PROG, 24'h00AB10}, 32);
    host_u.send_bits(8'hA7, 8);
    host_u.send_bits(4'h9, 4);
    host_u.close_frame();
    repeat (10) @(posedge core_clk);
    #1;
    check("partial byte", n, execCount);
    check("wel kept", 1, writeEnableLatch);
    host_u.open_frame();
    host_u.send_bits({`SFD_OP_PAGE_PROG, 24'h00AB10}, 32);
    host_u.send_bits(8'hA7, 8);
    host_u.close_frame();
    repeat (10) @(posedge core_clk);
    #1;
    check("program accept", n + 1, execCount);
    check("program addr", 24'h00AB10, execAddr);
    check("program data", 8'hA7, wrData);
    check("wel after program", 0, writeEnableLatch);
  endtask
  task automatic t_read();
    host_u.open_frame();
    host_u.send_bits({`SFD_OP_READ, 24'h12345E}, 32);
    host_u.get_byte(b0);
    host_u.get_byte(b1);
    host_u.close_frame();
    check("read byte 0", 8'h5E ^ 8'hC3, b0);
    check("read byte 1", 8'h5F ^ 8'hC3, b1);
    host_u.open_frame();
    host_u.send_bits({`SFD_OP_FAST_READ, 24'h000070}, 32);
    host_u.send_bits(8'h00, 8);
    host_u.get_byte(b0);
    host_u.close_frame();
    check("fast read", 8'h70 ^ 8'hC3, b0);
  endtask
  task automatic t_erase();
    frame(`SFD_OP_WR_ENABLE, 8);
    frame({`SFD_OP_SECT_ERASE, 24'h03F000}, 32);
    check("erase opcode", `SFD_OP_SECT_ERASE, execOpcode);
    check("erase addr", 24'h03F000, execAddr);
    frame(`SFD_OP_WR_ENABLE, 8);
    frame(`SFD_OP_CHIP_ERASE_A, 8);
    check("chip erase", `SFD_OP_CHIP_ERASE_A, execOpcode);
  endtask
  task automatic t_power();
    frame(`SFD_OP_POWER_DOWN, 8);
    check("power down", 1, deepPowerDown);
    n = execCount;
    host_u.open_frame();
    host_u.send_bits(`SFD_OP_STAT_RD1, 8);
    host_u.get_byte(b0);
    check("no drive asleep", 4'h0, ioOe);
    host_u.close_frame();
    check("ignored asleep", n, execCount);
    frame(`SFD_OP_RELEASE, 8);
    check("released", 0, deepPowerDown);
    host_u.open_frame();
    host_u.send_bits({`SFD_OP_RELEASE, 24'h000000}, 32);
    host_u.get_byte(b0);
    host_u.get_byte(b1);
    host_u.close_frame();
    check("part id", 8'h3C, b0);
    check("part id again", 8'h3C, b1);
  endtask
  task automatic t_misc();
    host_u.open_frame();
    host_u.send_bits({`SFD_OP_ID_SINGLE, 24'h000000}, 32);
    host_u.get_byte(b0);
    host_u.get_byte(b1);
    host_u.close_frame();
    check("maker byte", 8'h5A, b0);
    check("part byte", 8'h3C, b1);
    host_u.open_frame();
    host_u.send_bits({`SFD_OP_WRAP, 6'h00}, 14);
    host_u.send_quad(8'h96, 2);
    host_u.close_frame();
    check("wrap bits", 8'h96, wrapConfigBits);
    host_u.open_frame();
    host_u.send_bits(`SFD_OP_ID_QUAD, 8);
    host_u.send_quad(32'h000000A6, 8);
    host_u.close_frame();
    check("mode bits", 8'hA6, continuousModeBits);
    n = execCount;
    frame(8'h9F, 8);
    check("unknown ignored", n, execCount);
    n = softCount;
    frame(`SFD_OP_RESET_EN, 8);
    frame(`SFD_OP_RESET, 8);
    check("soft reset", n + 1, softCount);
  endtask
  // Main sequence after a 12-cycle reset
  initial begin
    rst = 1'b1;
    statusByte1 = 8'h00;
    statusByte2 = 8'h00;
    statusByte3 = 8'h00;
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    t_latch();
    t_status();
    t_program();
    t_read();
    t_erase();
    t_power();
    t_misc();
    complete_run();
  end
  // Watchdog: the sequence needs well under a millisecond
  initial begin
    #3000000;
    bad_count++;
    complete_run();
  end
endmodule // sfd_flash_decoder_test
